// ==== bench/cio_bank_bench.sv ====
// Self-checking bench for the indirectly addressed output configuration bank.
`timescale 1ns/1ns
module cio_bank_bench
  import cio_pkg::*;
;
  typedef struct {logic [7:0] off; logic [7:0] wdata; logic [7:0] exp;} cio_row_type;
  logic ref_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  logic link_good;
  logic [11:0] raw_pixel;
  logic [23:0] colour_bus;
  logic p0_ctl, p0_en, p1_ctl, p1_en;
  logic [5:0] p0_field, p1_field;
  logic pin0_out, pin0_oe_n, pin3_out, pin3_oe_n;
  logic [1:0] virtual_channel;
  logic [7:0] rd_val;
  int miscompares = 0;
  int num_checks = 0;
  cio_row_type rows [10] = '{'{8'h09, 8'hFF, 8'h10}, '{8'h09, 8'h00, 8'h00}, '{8'h13, 8'hFF, 8'hBF},
    '{8'h13, 8'h00, 8'h00}, '{8'h14, 8'h3F, 8'h3F}, '{8'h14, 8'h40, 8'h00}, '{8'h2E, 8'hFF, 8'hC0},
    '{8'h2E, 8'h3F, 8'h00}, '{8'h20, 8'hFF, 8'h00}, '{8'h16, 8'hFF, 8'h06}};

  cio_bank cio_bank_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .link_good(link_good), .raw_pixel(raw_pixel), .colour_bus(colour_bus), .port0_reg_control(p0_ctl),
    .port0_enable_field(p0_field), .port0_enabled(p0_en), .port1_reg_control(p1_ctl),
    .port1_enable_field(p1_field), .port1_enabled(p1_en), .general_pin_zero_out(pin0_out),
    .general_pin_zero_oe_n(pin0_oe_n), .general_pin_three_out(pin3_out),
    .general_pin_three_oe_n(pin3_oe_n), .virtual_channel(virtual_channel));

  // ****************************************************************
  // Clock, comparison and bus tasks
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // The strobe is dropped at the taking edge and the task returns one edge later, so outputs have settled.
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check("rvalid", 24'h00_0001, {23'h0, reg_rvalid});
    data = reg_rdata;
    @(posedge ref_clk);
  endtask : reg_read

  task automatic ind_write(input logic [7:0] off, input logic [7:0] data);
    reg_write(CIO_ADDR_INDIRECT, off);
    reg_write(CIO_ADDR_DATA, data);
  endtask : ind_write

  task automatic ind_check(input logic [7:0] off, input logic [7:0] exp);
    reg_write(CIO_ADDR_INDIRECT, off);
    reg_read(CIO_ADDR_DATA, rd_val);
    check("bank readback", {16'h0, exp}, {16'h0, rd_val});
  endtask : ind_check

  task automatic reset_and_check();
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    ind_check(8'h09, 8'h00);
    ind_check(8'h13, 8'h3F);
    ind_check(8'h14, 8'h00);
    ind_check(8'h16, {6'h0, 1'b1, link_good});
    ind_check(8'h2E, 8'h00);
    check("reset pins", 24'h00_0009, {20'h0, p0_en, p1_en, pin0_oe_n, pin3_oe_n});
  endtask : reset_and_check

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    link_good = 1'b0;
    raw_pixel = 12'h000;
    reset_and_check();
    foreach (rows[i]) begin
      ind_write(rows[i].off, rows[i].wdata);
      ind_check(rows[i].off, rows[i].exp);
    end
    // Port enables and control bits, off code on port 0 and on code on port 1.
    ind_write(8'h13, 8'h80);
    ind_write(8'h14, 8'hBF);
    check("port outs", 24'h00_000B, {20'h0, p0_ctl, p0_en, p1_ctl, p1_en});
    check("port fields", {12'h0, 6'h00, 6'h3F}, {12'h0, p0_field, p1_field});
    for (int v = 0; v < 4; v++) begin
      ind_write(8'h2E, {v[1:0], 6'h15});
      check("channel", 24'(v), {22'h0, virtual_channel});
    end
    // Raw placement on the colour bus.
    raw_pixel <= 12'hABC;
    ind_write(8'h09, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("colour low", 24'h00_0ABC, colour_bus);
    ind_write(8'h09, 8'h10);
    repeat (2) @(posedge ref_clk);
    check("colour high", 24'hAB_C000, colour_bus);
    // Link-good routing: pin three only, then pin zero only, then none, status still live.
    link_good <= 1'b1;
    ind_write(8'h16, 8'h04);
    repeat (4) @(posedge ref_clk);
    check("route three", 24'h00_0005, {21'h0, pin0_oe_n, pin3_oe_n, pin3_out});
    ind_check(8'h16, 8'h05);
    ind_write(8'h16, 8'h02);
    check("route zero", 24'h00_0003, {21'h0, pin0_oe_n, pin3_oe_n, pin0_out});
    ind_write(8'h16, 8'h00);
    ind_check(8'h16, 8'h01);
    link_good <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ind_check(8'h16, 8'h00);
    // Indirect address readback, unclaimed address, no auto-increment.
    reg_write(CIO_ADDR_INDIRECT, 8'h14);
    reg_read(CIO_ADDR_INDIRECT, rd_val);
    check("index", 24'h00_0114, {15'h0, reg_hit, rd_val});
    reg_read(8'h6E, rd_val);
    check("unclaimed", 24'h00_0000, {15'h0, reg_hit, rd_val});
    reg_write(8'h6E, 8'hFF);
    reg_read(CIO_ADDR_DATA, rd_val);
    reg_read(CIO_ADDR_DATA, rd_val);
    check("same index", 24'h00_00BF, {16'h0, rd_val});
    // A second reset in mid-run restores every default.
    link_good <= 1'b1;
    reset_and_check();
    test_done();
  end
endmodule : cio_bank_bench

// ==== design/cio_bank.sv ====
// Indirectly addressed output configuration bank with its address/data port pair.
`timescale 1ns/1ns
module cio_bank
  import cio_pkg::*;
#(
  parameter int RAW_W = 12,
  parameter int BUS_W = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  input wire logic link_good,
  input wire logic [RAW_W-1:0] raw_pixel,
  output logic [BUS_W-1:0] colour_bus,
  output logic port0_reg_control,
  output logic [5:0] port0_enable_field,
  output logic port0_enabled,
  output logic port1_reg_control,
  output logic [5:0] port1_enable_field,
  output logic port1_enabled,
  output logic general_pin_zero_out,
  output logic general_pin_zero_oe_n,
  output logic general_pin_three_out,
  output logic general_pin_three_oe_n,
  output logic [1:0] virtual_channel
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] indirect_address_port_reg;
  logic [7:0] raw_bus_placement_reg;
  logic [7:0] output_port0_enable_reg;
  logic [7:0] output_port1_enable_reg;
  logic [7:0] link_good_routing_reg;
  logic [7:0] virtual_channel_select_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [BUS_W-1:0] colour_bus_reg;
  logic pin_zero_reg;
  logic pin_three_reg;
  logic link_good_sync;

  // ****************************************************************
  // Link-good synchroniser
  // ****************************************************************
  // The indication comes from the link receiver, which is not on ref_clk.
  cio_sync #(
    .WIDTH(1),
    .STAGES(CIO_SYNC_STAGES)
  ) u_link_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(link_good),
    .sync_out(link_good_sync)
  );

  // ****************************************************************
  // Direct port decode
  // ****************************************************************
  wire sel_indirect = (reg_addr == CIO_ADDR_INDIRECT);
  wire sel_data = (reg_addr == CIO_ADDR_DATA);
  wire wr_indirect = reg_wr && sel_indirect;
  wire wr_data = reg_wr && sel_data;

  // ****************************************************************
  // Indirect offset decode
  // ****************************************************************
  wire [7:0] idx = indirect_address_port_reg;
  wire hit_raw = (idx == CIO_IDX_RAW_PLACE);
  wire hit_port0 = (idx == CIO_IDX_PORT0);
  wire hit_port1 = (idx == CIO_IDX_PORT1);
  wire hit_route = (idx == CIO_IDX_LINK_ROUTE);
  wire hit_vc = (idx == CIO_IDX_VC_SELECT);

  // ****************************************************************
  // Masked write values
  // ****************************************************************
  // Reserved bits are forced to their reset values on every write, so the
  // stored byte can be returned verbatim on a read, save the live status bit.
  wire [7:0] raw_wval = (reg_wdata & CIO_WMASK_RAW_PLACE) | (CIO_RST_RAW_PLACE & ~CIO_WMASK_RAW_PLACE);
  wire [7:0] port0_wval = (reg_wdata & CIO_WMASK_PORT) | (CIO_RST_PORT0 & ~CIO_WMASK_PORT);
  wire [7:0] port1_wval = (reg_wdata & CIO_WMASK_PORT) | (CIO_RST_PORT1 & ~CIO_WMASK_PORT);
  wire [7:0] route_wval = (reg_wdata & CIO_WMASK_LINK_ROUTE) | (CIO_RST_LINK_ROUTE & ~CIO_WMASK_LINK_ROUTE);
  wire [7:0] vc_wval = (reg_wdata & CIO_WMASK_VC_SELECT) | (CIO_RST_VC_SELECT & ~CIO_WMASK_VC_SELECT);

  // ****************************************************************
  // Read selection
  // ****************************************************************
  // The status bit is live: it always shows the synchronised indication.
  wire [7:0] route_rval = {link_good_routing_reg[7:1], link_good_sync};
  wire [7:0] bank_rval = hit_raw ? raw_bus_placement_reg :
                         hit_port0 ? output_port0_enable_reg :
                         hit_port1 ? output_port1_enable_reg :
                         hit_route ? route_rval :
                         hit_vc ? virtual_channel_select_reg :
                         8'h00;
  wire [7:0] rdata_next = sel_indirect ? indirect_address_port_reg :
                          sel_data ? bank_rval : 8'h00;

  // ****************************************************************
  // Colour bus placement
  // ****************************************************************
  wire [BUS_W-RAW_W-1:0] pad = '0;
  wire [BUS_W-1:0] colour_next = raw_bus_placement_reg[CIO_RAW_HIGH_BIT] ? {raw_pixel, pad} :
                                 {pad, raw_pixel};

  // ****************************************************************
  // Register updates
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      indirect_address_port_reg <= CIO_RST_INDIRECT;
    end else if (wr_indirect) begin
      indirect_address_port_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw_bus_placement_reg <= CIO_RST_RAW_PLACE;
      output_port0_enable_reg <= CIO_RST_PORT0;
      output_port1_enable_reg <= CIO_RST_PORT1;
      link_good_routing_reg <= CIO_RST_LINK_ROUTE;
      virtual_channel_select_reg <= CIO_RST_VC_SELECT;
    end else if (wr_data) begin
      if (hit_raw) begin
        raw_bus_placement_reg <= raw_wval;
      end
      if (hit_port0) begin
        output_port0_enable_reg <= port0_wval;
      end
      if (hit_port1) begin
        output_port1_enable_reg <= port1_wval;
      end
      if (hit_route) begin
        link_good_routing_reg <= route_wval;
      end
      if (hit_vc) begin
        virtual_channel_select_reg <= vc_wval;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : rdata_reg;
      rvalid_reg <= reg_rd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      colour_bus_reg <= '0;
      pin_zero_reg <= 1'b0;
      pin_three_reg <= 1'b0;
    end else begin
      colour_bus_reg <= colour_next;
      pin_zero_reg <= link_good_sync;
      pin_three_reg <= link_good_sync;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign reg_hit = sel_indirect || sel_data;
  assign colour_bus = colour_bus_reg;
  assign port0_reg_control = output_port0_enable_reg[CIO_REG_CTRL_BIT];
  assign port0_enable_field = output_port0_enable_reg[CIO_EN_MSB:CIO_EN_LSB];
  assign port0_enabled = (port0_enable_field == CIO_EN_ON);
  assign port1_reg_control = output_port1_enable_reg[CIO_REG_CTRL_BIT];
  assign port1_enable_field = output_port1_enable_reg[CIO_EN_MSB:CIO_EN_LSB];
  assign port1_enabled = (port1_enable_field == CIO_EN_ON);
  // A pin that is not routed is released so its other function can use it.
  assign general_pin_zero_out = pin_zero_reg;
  assign general_pin_zero_oe_n = ~link_good_routing_reg[CIO_ROUTE_PIN0_BIT];
  assign general_pin_three_out = pin_three_reg;
  assign general_pin_three_oe_n = ~link_good_routing_reg[CIO_ROUTE_PIN3_BIT];
  assign virtual_channel = virtual_channel_select_reg[CIO_VC_MSB:CIO_VC_LSB];

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_raw_low_place: assert property (
    @(posedge ref_clk) disable iff (rst)
    !raw_bus_placement_reg[CIO_RAW_HIGH_BIT] |=>
      colour_bus == {{(BUS_W-RAW_W){1'b0}}, $past(raw_pixel)})
    else $error("raw pixels not on low colour bits");

  chk_raw_high_place: assert property (
    @(posedge ref_clk) disable iff (rst)
    raw_bus_placement_reg[CIO_RAW_HIGH_BIT] |=>
      colour_bus == {$past(raw_pixel), {(BUS_W-RAW_W){1'b0}}})
    else $error("raw pixels not on high colour bits");

  chk_reg_ctrl_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && hit_port0 |=> port0_reg_control == $past(reg_wdata[CIO_REG_CTRL_BIT])
      && output_port0_enable_reg[6] == 1'b0)
    else $error("port 0 register control not written or reserved bit changed");

  chk_port0_reset: assert property (
    @(posedge ref_clk)
    rst |=> port0_enabled && port0_enable_field == 6'h3F && !port0_reg_control)
    else $error("port 0 not enabled after reset");

  chk_port1_reset: assert property (
    @(posedge ref_clk)
    rst |=> !port1_enabled && port1_enable_field == CIO_EN_OFF && !port1_reg_control)
    else $error("port 1 not disabled after reset");

  chk_pin_three_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    link_good_routing_reg[CIO_ROUTE_PIN3_BIT] && !(wr_data && hit_route) |=>
      !general_pin_three_oe_n && general_pin_three_out == $past(link_good_sync))
    else $error("pin three does not carry link good");

  chk_pin_zero_default: assert property (
    @(posedge ref_clk)
    rst |=> !general_pin_zero_oe_n && general_pin_three_oe_n)
    else $error("pin zero routing not default after reset");

  chk_status_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && sel_data && hit_route |=> reg_rvalid && reg_rdata[0] == $past(link_good_sync))
    else $error("status bit does not show link good");

  chk_vc_select: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && hit_vc ##1 !(wr_data && hit_vc) [*2] |->
      virtual_channel == $past(reg_wdata[CIO_VC_MSB:CIO_VC_LSB], 2))
    else $error("virtual channel does not follow written value");

  chk_indirect_order: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && sel_data && indirect_address_port_reg == CIO_IDX_PORT0 |=>
      reg_rdata == $past(output_port0_enable_reg))
    else $error("data port does not select the written offset");

  chk_unlisted_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && sel_data && !(hit_raw || hit_port0 || hit_port1 || hit_route || hit_vc) |=> reg_rdata == 8'h00)
    else $error("unlisted offset reads non-zero");

  chk_reserved_bits: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |-> raw_bus_placement_reg[3:0] == 4'h0 && raw_bus_placement_reg[7:5] == 3'h0
      && link_good_routing_reg[7:3] == 5'h00 && virtual_channel_select_reg[5:0] == 6'h00)
    else $error("reserved bits changed");

  chk_pin_zero_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    link_good_routing_reg[CIO_ROUTE_PIN0_BIT] && !(wr_data && hit_route) |=>
      !general_pin_zero_oe_n && general_pin_zero_out == $past(link_good_sync))
    else $error("pin zero does not carry link good");

  chk_pin_three_release: assert property (
    @(posedge ref_clk) disable iff (rst)
    !link_good_routing_reg[CIO_ROUTE_PIN3_BIT] && !(wr_data && hit_route) |=>
      general_pin_three_oe_n)
    else $error("pin three driven while not routed");

  chk_port1_ctrl_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && hit_port1 |=> port1_reg_control == $past(reg_wdata[CIO_REG_CTRL_BIT])
      && output_port1_enable_reg[6] == 1'b0)
    else $error("port 1 register control not written or reserved bit changed");

  chk_port0_field_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && hit_port0 |=>
      port0_enable_field == $past(reg_wdata[CIO_EN_MSB:CIO_EN_LSB]))
    else $error("port 0 enable field not written");

  chk_port1_field_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && hit_port1 |=>
      port1_enable_field == $past(reg_wdata[CIO_EN_MSB:CIO_EN_LSB]))
    else $error("port 1 enable field not written");

  chk_read_valid_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read valid does not follow the read strobe");

endmodule : cio_bank

// ==== design/cio_pkg.sv ====
// Constants for the indirectly addressed output configuration bank.
package cio_pkg;

  // ****************************************************************
  // Direct map locations of the indirect port pair
  // ****************************************************************
  localparam logic [7:0] CIO_ADDR_INDIRECT = 8'h6C;
  localparam logic [7:0] CIO_ADDR_DATA = 8'h6D;

  // ****************************************************************
  // Indirect bank offsets
  // ****************************************************************
  localparam logic [7:0] CIO_IDX_RAW_PLACE = 8'h09;
  localparam logic [7:0] CIO_IDX_PORT0 = 8'h13;
  localparam logic [7:0] CIO_IDX_PORT1 = 8'h14;
  localparam logic [7:0] CIO_IDX_LINK_ROUTE = 8'h16;
  localparam logic [7:0] CIO_IDX_VC_SELECT = 8'h2E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CIO_RAW_HIGH_BIT = 4;
  localparam int CIO_REG_CTRL_BIT = 7;
  localparam int CIO_EN_MSB = 5;
  localparam int CIO_EN_LSB = 0;
  localparam int CIO_ROUTE_PIN3_BIT = 2;
  localparam int CIO_ROUTE_PIN0_BIT = 1;
  localparam int CIO_LINK_STATUS_BIT = 0;
  localparam int CIO_VC_MSB = 7;
  localparam int CIO_VC_LSB = 6;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [5:0] CIO_EN_ON = 6'h3F;
  localparam logic [5:0] CIO_EN_OFF = 6'h00;

  // ****************************************************************
  // Reset values and writable-bit masks
  // ****************************************************************
  localparam logic [7:0] CIO_RST_INDIRECT = 8'h00;
  localparam logic [7:0] CIO_RST_RAW_PLACE = 8'h00;
  localparam logic [7:0] CIO_RST_PORT0 = 8'h3F;
  localparam logic [7:0] CIO_RST_PORT1 = 8'h00;
  localparam logic [7:0] CIO_RST_LINK_ROUTE = 8'h02;
  localparam logic [7:0] CIO_RST_VC_SELECT = 8'h00;
  localparam logic [7:0] CIO_WMASK_RAW_PLACE = 8'h10;
  localparam logic [7:0] CIO_WMASK_PORT = 8'hBF;
  localparam logic [7:0] CIO_WMASK_LINK_ROUTE = 8'h06;
  localparam logic [7:0] CIO_WMASK_VC_SELECT = 8'hC0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CIO_SYNC_STAGES = 2;

endpackage : cio_pkg

// ==== design/cio_sync.sv ====
// Multi-stage level synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module cio_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // Flop chain
  // ****************************************************************
  // Only the last stage is visible outside, so no logic ever looks at a
  // possibly metastable first stage.
  logic [WIDTH-1:0] chain_reg [STAGES];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_reg[i] <= '0;
      end
    end else begin
      chain_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        chain_reg[i] <= chain_reg[i-1];
      end
    end
  end

  assign sync_out = chain_reg[STAGES-1];

endmodule : cio_sync
